//--- logic/cond_decode_map.vh
// Constants for the condition-code and operand decoder.
// Assumes inclusion by bare name from the decoder source only.
`ifndef COND_DECODE_MAP_VH
`define COND_DECODE_MAP_VH
// ==================================================================
// Condition codes in opcode bits 7:4
`define CC_HI 7
`define CC_LO 4
`define CC_NEVER 4'h0
`define CC_SIGNED_BELOW 4'h1
`define CC_SIGNED_AT_MOST 4'h2
`define CC_UNSIGNED_AT_MOST 4'h3
`define CC_ARITH_WRAP_SET 4'h4
`define CC_NEGATIVE_RESULT 4'h5
`define CC_SAME_VALUE 4'h6
`define CC_UNSIGNED_BELOW 4'h7
`define CC_ALWAYS 4'h8
`define CC_SIGNED_AT_LEAST 4'h9
`define CC_SIGNED_ABOVE 4'ha
`define CC_UNSIGNED_ABOVE 4'hb
`define CC_ARITH_WRAP_CLEAR 4'hc
`define CC_POSITIVE_RESULT 4'hd
`define CC_DIFFERENT_VALUE 4'he
`define CC_BORROW_FREE 4'hf
// ==================================================================
// Operand kinds, named by the fetch unit along with the opcode
`define KIND_REG8 4'h0
`define KIND_PAIR 4'h1
`define KIND_WPAIR 4'h2
`define KIND_EXT12 4'h3
`define KIND_DA16 4'h4
`define KIND_BIT 4'h5
`define KIND_REL 4'h6
`define KIND_IDX 4'h7
`define KIND_ADD_RR 4'h8
// ==================================================================
// Operand byte counts per kind
`define LEN_ONE 2'h1
`define LEN_TWO 2'h2
// ==================================================================
// Escaped working-register form and the register-to-register add
`define ESC_NIBBLE 4'he
`define ADD_RR_OPC 8'h04
// ==================================================================
// One-hot sequencer states
`define ST_IDLE 3'h1
`define ST_OPND 3'h2
`define ST_DONE 3'h4
`endif

//--- logic/cond_code_operand_decode.v
// Condition-code evaluation and operand field decode for the core.
// Assumes the fetch unit presents one opcode byte, then its operand
// bytes, all synchronous to core_clk, and names the operand kind.
`default_nettype none
`include "cond_decode_map.vh"

// Operation
// - Condition code taken from opcode bits 7:4
// - Jump decision uses only carry, zero, sign, overflow
// - Code 0 never jumps, code 8 always
// - signed_below from sign xor overflow; signed_at_most adds zero
// - signed_at_least, signed_above are their inverses
// - unsigned_at_most carry or zero; unsigned_above neither
// - Code 7 carry set, code f carry clear
// - Codes 4-6 flag set, c-e flag clear
// - Register byte 0-255, escaped form selects working register
// - Add opcode 04 takes source byte first
// - Relative offset signed, added to next address
// - Index is signed offset from base register
// - Register pair is even address 00 to fe
// - Extended register address is 12 bits
// - Direct address is 16 bits
// - Bit select is three bits, 0 to 7
// - Polarity is a single bit
module cond_code_operand_decode (
   input wire core_clk,
   input wire rst_b,
   input wire flagWrite,
   input wire carryIn,
   input wire zeroIn,
   input wire signIn,
   input wire overflowIn,
   input wire opcodeValid,
   input wire [7:0] opcodeByte,
   input wire opcodeCond,
   input wire [3:0] opndKind,
   input wire operandValid,
   input wire [7:0] operandByte,
   input wire [15:0] nextPc,
   output wire decodeBusy,
   output reg condValid,
   output reg [3:0] ccCode,
   output reg condTaken,
   output reg opndDone,
   output reg [11:0] regAddr,
   output reg workSel,
   output reg [3:0] workReg,
   output reg pairOk,
   output reg [2:0] bitSel,
   output reg polarity,
   output reg [15:0] target,
   output reg [7:0] srcAddr,
   output reg srcWork,
   output reg [7:0] dstAddr,
   output reg dstWork
);

   // ===============================================================
   // Flag store
   reg carry;
   reg zero;
   reg sign;
   reg overflow;
   wire effCarry;
   wire effZero;
   wire effSign;
   wire effOver;
   wire jumpNow;

   // ===============================================================
   // Sequencer state
   reg [2:0] state;
   reg [2:0] next_state;
   reg [3:0] kind;
   reg [1:0] need;
   reg [1:0] got;
   reg [7:0] firstByte;
   reg [15:0] pcHold;
   wire [1:0] kindLen;
   wire lastByte;
   wire [7:0] headByte;

   // ===============================================================
   // Next values of the decoded fields
   reg [11:0] next_regAddr;
   reg next_workSel;
   reg [3:0] next_workReg;
   reg next_pairOk;
   reg [2:0] next_bitSel;
   reg next_polarity;
   reg [15:0] next_target;
   reg [7:0] next_srcAddr;
   reg next_srcWork;
   reg [7:0] next_dstAddr;
   reg next_dstWork;

   // ===============================================================
   // Condition test; nothing but the four flags enters it
   function condTrue;
      input [3:0] cc;
      input c;
      input z;
      input s;
      input v;
      begin
         case (cc)
            `CC_NEVER: condTrue = 1'b0;
            `CC_SIGNED_BELOW: condTrue = s ^ v;
            `CC_SIGNED_AT_MOST: condTrue = z | (s ^ v);
            `CC_UNSIGNED_AT_MOST: condTrue = c | z;
            `CC_ARITH_WRAP_SET: condTrue = v;
            `CC_NEGATIVE_RESULT: condTrue = s;
            `CC_SAME_VALUE: condTrue = z;
            `CC_UNSIGNED_BELOW: condTrue = c;
            `CC_ALWAYS: condTrue = 1'b1;
            `CC_SIGNED_AT_LEAST: condTrue = ~(s ^ v);
            `CC_SIGNED_ABOVE: condTrue = ~(z | (s ^ v));
            `CC_UNSIGNED_ABOVE: condTrue = ~c & ~z;
            `CC_ARITH_WRAP_CLEAR: condTrue = ~v;
            `CC_POSITIVE_RESULT: condTrue = ~s;
            `CC_DIFFERENT_VALUE: condTrue = ~z;
            `CC_BORROW_FREE: condTrue = ~c;
            default: condTrue = 1'b0;
         endcase
      end
   endfunction

   // Operand byte count per kind; unknown kinds take one byte
   function [1:0] lenOf;
      input [3:0] k;
      begin
         case (k)
            `KIND_EXT12: lenOf = `LEN_TWO;
            `KIND_DA16: lenOf = `LEN_TWO;
            `KIND_IDX: lenOf = `LEN_TWO;
            `KIND_ADD_RR: lenOf = `LEN_TWO;
            default: lenOf = `LEN_ONE;
         endcase
      end
   endfunction

   // ===============================================================
   // Latch each completed flag update
   always @(posedge core_clk) begin
      if (!rst_b) begin
         carry <= 1'b0;
         zero <= 1'b0;
         sign <= 1'b0;
         overflow <= 1'b0;
      end else if (flagWrite) begin
         carry <= carryIn;
         zero <= zeroIn;
         sign <= signIn;
         overflow <= overflowIn;
      end
   end

   // Forward an update landing with the opcode, so a jump right
   // after a compare sees the fresh flags without a stall
   assign effCarry = flagWrite ? carryIn : carry;
   assign effZero = flagWrite ? zeroIn : zero;
   assign effSign = flagWrite ? signIn : sign;
   assign effOver = flagWrite ? overflowIn : overflow;

   // Evaluate on the opcode's own code field
   assign jumpNow = condTrue(opcodeByte[`CC_HI:`CC_LO], effCarry,
      effZero, effSign, effOver);

   // ===============================================================
   // Condition result, one cycle after the opcode, before next fetch
   always @(posedge core_clk) begin
      if (!rst_b) begin
         condValid <= 1'b0;
         ccCode <= `CC_NEVER;
         condTaken <= 1'b0;
      end else begin
         condValid <= 1'b0;
         if (opcodeValid && opcodeCond && (state == `ST_IDLE)) begin
            condValid <= 1'b1;
            ccCode <= opcodeByte[`CC_HI:`CC_LO];
            condTaken <= jumpNow;
         end
      end
   end

   // ===============================================================
   // Sequencer: opcode, then its operand bytes
   assign decodeBusy = (state != `ST_IDLE);
   // The add opcode overrides whatever kind the fetch unit named
   assign kindLen = (opcodeByte == `ADD_RR_OPC) ? `LEN_TWO : lenOf(opndKind);
   assign lastByte = operandValid && (got == (need - 2'h1));
   // First byte comes from the hold register unless it arrives now
   assign headByte = (got == 2'h0) ? operandByte : firstByte;

   always @* begin
      next_state = state;
      case (state)
         `ST_IDLE: begin
            if (opcodeValid) begin
               next_state = `ST_OPND;
            end
         end
         `ST_OPND: begin
            if (lastByte) begin
               next_state = `ST_DONE;
            end
         end
         `ST_DONE: next_state = `ST_IDLE;
         default: next_state = `ST_IDLE;
      endcase
   end

   // Bytes outside their phase are dropped: opcodes while busy,
   // operands while idle
   always @(posedge core_clk) begin
      if (!rst_b) begin
         state <= `ST_IDLE;
         kind <= `KIND_REG8;
         need <= `LEN_ONE;
         got <= 2'h0;
         firstByte <= 8'h00;
         pcHold <= 16'h0000;
      end else begin
         state <= next_state;
         if (state == `ST_IDLE && opcodeValid) begin
            kind <= (opcodeByte == `ADD_RR_OPC) ? `KIND_ADD_RR : opndKind;
            need <= kindLen;
            got <= 2'h0;
            pcHold <= nextPc;
         end else if (state == `ST_OPND && operandValid) begin
            got <= got + 2'h1;
            if (got == 2'h0) begin
               firstByte <= operandByte;
            end
         end
      end
   end

   // ===============================================================
   // Field decode from the head byte and the byte arriving now
   always @* begin
      next_regAddr = regAddr;
      next_workSel = workSel;
      next_workReg = workReg;
      next_pairOk = pairOk;
      next_bitSel = bitSel;
      next_polarity = polarity;
      next_target = target;
      next_srcAddr = srcAddr;
      next_srcWork = srcWork;
      next_dstAddr = dstAddr;
      next_dstWork = dstWork;
      case (kind)
         `KIND_REG8: begin
            // Escape nibble selects a working reg; regAddr still takes the plain byte
            next_workSel = (headByte[7:4] == `ESC_NIBBLE);
            next_workReg = headByte[3:0];
            next_regAddr = {4'h0, headByte};
         end
         `KIND_PAIR: begin
            next_regAddr = {4'h0, headByte};
            next_pairOk = ~headByte[0];
            next_workSel = 1'b0;
         end
         `KIND_WPAIR: begin
            next_workSel = 1'b1;
            next_workReg = headByte[3:0];
            next_pairOk = ~headByte[0];
         end
         `KIND_EXT12: begin
            next_regAddr = {headByte[3:0], operandByte};
            next_workSel = 1'b0;
         end
         `KIND_DA16: begin
            next_target = {headByte, operandByte};
         end
         `KIND_BIT: begin
            next_bitSel = headByte[3:1];
            next_polarity = headByte[0];
         end
         `KIND_REL: begin
            // Offset counts from the following instruction
            next_target = pcHold + {{8{headByte[7]}}, headByte};
         end
         `KIND_IDX: begin
            // Sum wraps within the 12-bit register space
            next_regAddr = {4'h0, headByte} + {{4{operandByte[7]}}, operandByte};
            next_workSel = 1'b0;
         end
         `KIND_ADD_RR: begin
            next_srcAddr = headByte;
            next_srcWork = (headByte[7:4] == `ESC_NIBBLE);
            next_dstAddr = operandByte;
            next_dstWork = (operandByte[7:4] == `ESC_NIBBLE);
         end
         default: begin
            next_regAddr = regAddr;
         end
      endcase
   end

   // ===============================================================
   // Decoded fields update only on the final operand byte
   always @(posedge core_clk) begin
      if (!rst_b) begin
         opndDone <= 1'b0;
         regAddr <= 12'h000;
         workSel <= 1'b0;
         workReg <= 4'h0;
         pairOk <= 1'b0;
         bitSel <= 3'h0;
         polarity <= 1'b0;
         target <= 16'h0000;
         srcAddr <= 8'h00;
         srcWork <= 1'b0;
         dstAddr <= 8'h00;
         dstWork <= 1'b0;
      end else begin
         opndDone <= 1'b0;
         if (state == `ST_OPND && lastByte) begin
            opndDone <= 1'b1;
            regAddr <= next_regAddr;
            workSel <= next_workSel;
            workReg <= next_workReg;
            pairOk <= next_pairOk;
            bitSel <= next_bitSel;
            polarity <= next_polarity;
            target <= next_target;
            srcAddr <= next_srcAddr;
            srcWork <= next_srcWork;
            dstAddr <= next_dstAddr;
            dstWork <= next_dstWork;
         end
      end
   end

endmodule
`default_nettype wire

//--- sim/cond_decode_checker.sv
// Assertions on the condition decision of the decoder.
// Assumes binding to the decoder: one clock, sync active-low reset.
`default_nettype none
module cond_decode_checker (
   input wire core_clk,
   input wire rst_b,
   input wire flagWrite,
   input wire carryIn,
   input wire zeroIn,
   input wire signIn,
   input wire overflowIn,
   input wire opcodeValid,
   input wire [7:0] opcodeByte,
   input wire opcodeCond,
   input wire decodeBusy,
   input wire condValid,
   input wire [3:0] ccCode,
   input wire condTaken
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   // ======================================
   // Flag copy; an update in the opcode cycle is forwarded
   logic [3:0] fl;
   always_ff @(posedge core_clk) begin
      if (!rst_b) fl <= 4'h0;
      else if (flagWrite) fl <= {carryIn, zeroIn, signIn, overflowIn};
   end
   wire [3:0] cur = flagWrite ? {carryIn, zeroIn, signIn, overflowIn} : fl;
   wire cy = cur[3];
   wire vf = cur[0];
   wire sxv = cur[1] ^ cur[0];
   wire nrz = ~(cur[3] | cur[2]);
   wire st = opcodeValid && opcodeCond && !decodeBusy;
   wire [3:0] cc = opcodeByte[7:4];
   // ======================================
   // Decision lands one cycle after a conditional opcode is taken
   a_cond_pulse_once: assert property (st |=> condValid ##1 !condValid)
      else $error("condition pulse wrong");
   a_cc_field: assert property (st |=> ccCode == $past(cc))
      else $error("condition code field wrong");
   a_never_taken: assert property (st && cc == 4'h0 |=> !condTaken)
      else $error("code 0 jumped");
   a_always_taken: assert property (st && cc == 4'h8 |=> condTaken)
      else $error("code 8 did not jump");
   a_signed_below: assert property (st && cc == 4'h1 |=> condTaken == $past(sxv))
      else $error("code 1 wrong");
   a_unsigned_above: assert property (st && cc == 4'hb |=> condTaken == $past(nrz))
      else $error("code b wrong");
   a_carry_set: assert property (st && cc == 4'h7 |=> condTaken == $past(cy))
      else $error("code 7 wrong");
   a_wrap_set: assert property (st && cc == 4'h4 |=> condTaken == $past(vf))
      else $error("code 4 wrong");
endmodule
bind cond_code_operand_decode cond_decode_checker u_chk (.core_clk, .rst_b, .flagWrite,
   .carryIn, .zeroIn, .signIn, .overflowIn, .opcodeValid, .opcodeByte, .opcodeCond,
   .decodeBusy, .condValid, .ccCode, .condTaken);
`default_nettype wire

//--- sim/fetch_model.sv
// Fetch-unit model: hands over an opcode, then its operand bytes.
// Assumes calls begin just after a rising edge of core_clk.
`default_nettype none
module fetch_model (
   input wire logic core_clk,
   input wire logic decodeBusy,
   output logic opcodeValid,
   output logic [7:0] opcodeByte,
   output logic opcodeCond,
   output logic [3:0] opndKind,
   output logic operandValid,
   output logic [7:0] operandByte,
   output logic [15:0] nextPc
);
   timeunit 1ns;
   timeprecision 100ps;
   // Quiet lines at start
   initial begin
      opcodeValid = 1'b0;
      opcodeByte = 8'h00;
      opcodeCond = 1'b0;
      opndKind = 4'h0;
      operandValid = 1'b0;
      operandByte = 8'h00;
      nextPc = 16'h0000;
   end
   task automatic step();
      @(posedge core_clk);
      #1;
   endtask
   // ======================================
   // One instruction; released lines carry inverted data so a stale
   // value never passes for a fresh one. Slow mode leaves a gap.
   task automatic issue(input logic [7:0] op, input logic c, input logic [3:0] k,
         input logic [7:0] b0, input logic [7:0] b1, input logic two, input logic slow,
         input logic [15:0] pc);
      for (int n = 0; n < 20 && decodeBusy !== 1'b0; n++)
         step();
      opcodeValid = 1'b1;
      opcodeByte = op;
      opcodeCond = c;
      opndKind = k;
      nextPc = pc;
      step();
      opcodeValid = 1'b0;
      opcodeByte = ~op;
      opcodeCond = ~c;
      opndKind = ~k;
      nextPc = ~pc;
      operandValid = 1'b1;
      operandByte = b0;
      step();
      if (two) begin
         if (slow) begin
            // The gap carries a stray always-jump, which a busy decoder drops
            operandValid = 1'b0;
            operandByte = ~b0;
            opcodeValid = 1'b1;
            opcodeByte = 8'h83;
            opcodeCond = 1'b1;
            step();
            opcodeValid = 1'b0;
            opcodeByte = ~op;
            opcodeCond = ~c;
            operandValid = 1'b1;
         end
         operandByte = b1;
         step();
      end
      operandValid = 1'b0;
      operandByte = ~operandByte;
      step();
   endtask
endmodule
`default_nettype wire

//--- sim/testbench.sv
// Self-checking bench for the condition and operand decoder.
// Assumes the fetch model drives the opcode side; flags come from here.
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic core_clk, rst_b, flagWrite, carryIn, zeroIn, signIn, overflowIn;
   logic opcodeValid, opcodeCond, operandValid, decodeBusy, condValid, condTaken;
   logic opndDone, workSel, pairOk, polarity, srcWork, dstWork;
   logic [7:0] opcodeByte, operandByte, srcAddr, dstAddr;
   logic [3:0] opndKind, ccCode, workReg;
   logic [2:0] bitSel;
   logic [11:0] regAddr;
   logic [15:0] nextPc, target;
   logic [51:0] w;
   int failures = 0;
   int checkCount = 0;
   int cycles = 0;
   int doneCount = 0;
   int doneBase = 0;
   // Jump outcome per code, bit index {carry,zero,sign,overflow}
   logic [15:0] truth [16] = '{16'h0000, 16'h6666, 16'hf6f6, 16'hfff0, 16'haaaa, 16'hcccc,
      16'hf0f0, 16'hff00, 16'hffff, 16'h9999, 16'h0909, 16'h000f, 16'h5555, 16'h3333,
      16'h0f0f, 16'h00ff};
   // Rows: opcode, kind, byte0, byte1, {slow,two}, field, expected
   // The last row names an unknown kind: one byte, fields hold
   logic [51:0] rows [21] = '{52'h10_0_e8_00_0_1_0018, 52'h10_0_e8_00_0_0_00e8,
      52'h10_0_ff_00_0_1_000f, 52'h10_1_fe_00_0_2_0001, 52'h10_1_fe_00_0_0_00fe,
      52'h10_1_03_00_0_2_0000, 52'h10_2_0e_00_0_1_001e, 52'h10_2_07_00_0_2_0000,
      52'h10_3_0f_ff_1_0_0fff, 52'h10_4_ff_ff_1_4_ffff, 52'h10_4_12_34_1_4_1234,
      52'h10_5_0f_00_0_3_000f, 52'h10_5_00_00_0_3_0000, 52'h10_6_7f_ff_0_4_006f,
      52'h10_6_80_00_0_4_0070, 52'h10_7_f0_7f_1_0_016f, 52'h10_7_10_80_1_0_0f90,
      52'h04_0_80_43_1_5_0080, 52'h04_0_80_43_3_6_0043, 52'h04_0_e8_43_1_5_01e8,
      52'h10_9_55_00_0_0_0f90};
   cond_code_operand_decode u_dut (.core_clk, .rst_b, .flagWrite, .carryIn, .zeroIn,
      .signIn, .overflowIn, .opcodeValid, .opcodeByte, .opcodeCond, .opndKind,
      .operandValid, .operandByte, .nextPc, .decodeBusy, .condValid, .ccCode, .condTaken,
      .opndDone, .regAddr, .workSel, .workReg, .pairOk, .bitSel, .polarity, .target,
      .srcAddr, .srcWork, .dstAddr, .dstWork);
   fetch_model u_fetch (.core_clk, .decodeBusy, .opcodeValid, .opcodeByte, .opcodeCond,
      .opndKind, .operandValid, .operandByte, .nextPc);
   // ======================================
   // Helpers
   task automatic finalReport();
      $display("checks %0d, mismatches %0d", checkCount, failures);
      if (failures == 0 && checkCount > 0) begin
         $display("[ PASS ]");
      end
      else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checkCount++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // Flag lines go to inverted values afterwards: only the strobe may count
   task automatic setFlags(input logic [3:0] f);
      flagWrite = 1'b1;
      {carryIn, zeroIn, signIn, overflowIn} = f;
      @(posedge core_clk);
      #1;
      flagWrite = 1'b0;
      {carryIn, zeroIn, signIn, overflowIn} = ~f;
   endtask
   function automatic logic [15:0] pick(input logic [3:0] s);
      case (s)
         4'h0: pick = {4'h0, regAddr};
         4'h1: pick = {11'h0, workSel, workReg};
         4'h2: pick = {15'h0, pairOk};
         4'h3: pick = {12'h0, bitSel, polarity};
         4'h4: pick = target;
         4'h5: pick = {7'h0, srcWork, srcAddr};
         default: pick = {7'h0, dstWork, dstAddr};
      endcase
   endfunction
   // Clock, hang guard and a count of operand-done pulses
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cycles++;
      if (opndDone === 1'b1) begin
         doneCount++;
      end
      if (cycles == 6000) begin
         failures++;
         finalReport();
      end
   end
   // ======================================
   // Main sequence
   initial begin
      rst_b = 1'b0;
      flagWrite = 1'b0;
      {carryIn, zeroIn, signIn, overflowIn} = 4'h0;
      repeat (8) @(posedge core_clk);
      #1;
      rst_b = 1'b1;
      chk(decodeBusy, 1'b0);
      chk(target, 16'h0000);
      chk(regAddr, 12'h000);
      // Flags leave reset clear, so borrow_free holds
      u_fetch.issue(8'hf3, 1'b1, 4'h6, 8'h00, 8'h00, 1'b0, 1'b0, 16'h0000);
      chk(condTaken, 1'b1);
      for (int i = 0; i < 256; i++) begin
         setFlags(i[3:0]);
         u_fetch.issue({i[7:4], 4'h5}, 1'b1, 4'h6, 8'h00, 8'h00, 1'b0, 1'b0, 16'h0100);
         chk(ccCode, i[7:4]);
         chk(condTaken, truth[i[7:4]][i[3:0]]);
      end
      foreach (rows[r]) begin
         w = rows[r];
         doneBase = doneCount;
         u_fetch.issue(w[51:44], 1'b0, w[43:40], w[39:32], w[31:24], w[20], w[21],
            {w[31:24], 8'hf0});
         chk(pick(w[19:16]), w[15:0]);
         chk(16'(doneCount - doneBase), 16'h0001);
      end
      // The stray jump in the slow row must not have replaced code f
      chk(ccCode, 4'hf);
      chk(condTaken, 1'b0);
      // A flag update in the opcode's own cycle already counts
      setFlags(4'h0);
      fork
         setFlags(4'h8);
         u_fetch.issue(8'h73, 1'b1, 4'h6, 8'h00, 8'h00, 1'b0, 1'b0, 16'h0000);
      join
      chk(condTaken, 1'b1);
      u_fetch.issue(8'hf3, 1'b1, 4'h6, 8'h00, 8'h00, 1'b0, 1'b0, 16'h0000);
      chk(condTaken, 1'b0);
      u_fetch.issue(8'h83, 1'b1, 4'h6, 8'h00, 8'h00, 1'b0, 1'b0, 16'h0000);
      chk(condTaken, 1'b1);
      // Reset in mid-run clears the held results and the stored flags
      rst_b = 1'b0;
      @(posedge core_clk);
      #1;
      rst_b = 1'b1;
      chk(target, 16'h0000);
      chk(condTaken, 1'b0);
      chk(ccCode, 4'h0);
      chk(decodeBusy, 1'b0);
      u_fetch.issue(8'hf3, 1'b1, 4'h6, 8'h00, 8'h00, 1'b0, 1'b0, 16'h0000);
      chk(condTaken, 1'b1);
      finalReport();
   end
endmodule
`default_nettype wire
